// >>> include/lcdcd_defs.vh
// Constants shared by the LCD command decoder files.
`ifndef LCDCD_DEFS_VH
`define LCDCD_DEFS_VH

// Reset procedure time and clock period in nanoseconds.
`define LCDCD_RST_TIME_NS 100
`define LCDCD_CLK_PERIOD_NS 4
// Least time, rounded up to whole cycles.
`define LCDCD_RST_CYC \
  ((`LCDCD_RST_TIME_NS + `LCDCD_CLK_PERIOD_NS - 1) / `LCDCD_CLK_PERIOD_NS)

// Display memory geometry.
`define LCDCD_COLS 132
`define LCDCD_PAGES 9
`define LCDCD_MEM_WORDS 1188
`define LCDCD_ICON_PAGE 4'h8
`define LCDCD_LAST_COL 8'h83

// Host FIFO shape.
`define LCDCD_FIFO_W 10
`define LCDCD_FIFO_D 8
`define LCDCD_FIFO_AW 3

// Opcode values and the masks that pick their fixed bits.
`define LCDCD_M7 8'hFE
`define LCDCD_M6 8'hC0
`define LCDCD_M4 8'hF0
`define LCDCD_M3 8'hF8
`define LCDCD_OP_DISP 8'hAE
`define LCDCD_OP_LINE 8'h40
`define LCDCD_OP_PAGE 8'hB0
`define LCDCD_OP_COLH 8'h10
`define LCDCD_OP_COLL 8'h00
`define LCDCD_OP_SDIR 8'hA0
`define LCDCD_OP_INVERSE 8'hA6
`define LCDCD_OP_ALLP 8'hA4
`define LCDCD_OP_BIAS 8'hA2
`define LCDCD_OP_CDIR 8'hC0
`define LCDCD_OP_RMW 8'hE0
`define LCDCD_OP_END 8'hEE
`define LCDCD_OP_SRST 8'hE2
`define LCDCD_OP_NOP 8'hE3
`define LCDCD_OP_PWR 8'h28
`define LCDCD_OP_RATIO 8'h20
`define LCDCD_OP_VOL 8'h81
`define LCDCD_OP_BOOST 8'hF8
`define LCDCD_OP_TEST 8'hF0

// Reset values shared by both reset kinds.
`define LCDCD_RST_RATIO 3'h4
`define LCDCD_RST_VOLUME 6'h20

// Pending double-byte prefix states.
`define LCDCD_PEND_NONE 2'h0
`define LCDCD_PEND_VOL 2'h1
`define LCDCD_PEND_BOOST 2'h2

`endif

// >>> logic/lcdcd_fifo.v
// Synchronous FIFO holding host bytes ahead of the decoder.
`timescale 1ns/1ns
`default_nettype none
module lcdcd_fifo #(
  parameter W = 10,
  parameter D = 8,
  parameter AW = 3
) (
  // Clock, reset and clock enable.
  input wire clk,
  input wire reset,
  input wire clk_en,
  // Filling side.
  input wire in_valid,
  output reg in_ready_q,
  input wire [W-1:0] in_data,
  // Draining side.
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg [AW:0] cnt_d;
  wire push;
  wire pop;
  wire [AW:0] depth_w;

  assign depth_w = D[AW:0];
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = clk_en & in_valid & in_ready_q;
  assign pop = clk_en & out_valid & out_ready;

  // Next fill level; ready is registered so the port comes from a flop.
  always @* begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers, level and storage.
  always @(posedge clk) begin
    if (reset) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready_q <= 1'b1;
    end else if (clk_en) begin
      if (push) begin
        mem[wr_q] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != depth_w);
    end
  end
endmodule
`default_nettype wire

// >>> logic/lcdcd_top.v
// Command and data interpreter of a dot-matrix LCD controller.
//
// Contract
// - While reset pin is low, only status reads are accepted.
// - Hardware reset alone clears display, flags, bias, booster, power.
// - Both resets clear RMW, indicator, addresses, common scan, voltages.
// - Memory is undefined at power-on; host resets and fills memory first.
// - Byte 1010111x turns display on or off through display_on_q alone.
// - Byte 01ssssss stores display start line 0 to 63.
// - Byte 1011pppp selects page; icon page 8 keeps only bit 0.
// - Two bytes load column upper and lower nibbles separately.
// - Each data write and each read outside RMW advances column, stopping at column 83 hex.
// - Data write stores at page and column; data read returns it.
// - Status read gives busy, direction, display, reset; low bits zero.
// - Busy reads one while a command or reset procedure runs; here only the reset procedure raises it.
// - Reset bit reads one during hardware or software reset procedure.
// - No status or data reads in serial mode.
// - Bytes 10100xxx set segment reversal, inverse, all pixels, bias.
// - Byte 1100xyyy takes bit 3 as common direction, ignores the rest.
// - E0 enters RMW: reads keep column, writes advance; EE leaves.
// - Byte E2 starts software reset; byte E3 does nothing.
// - 00101abc sets power enables; 00100abc loads regulation ratio.
// - Byte 81 then a parameter byte loads six-bit volume.
// - Byte F8 then a parameter byte loads two-bit booster level.
// - Power save is display off together with all pixels on.
// - Leaving RMW restores the column held on entry.
// - Volume prefix waits for its parameter; both bytes go together.
`timescale 1ns/1ns
`default_nettype none
`include "lcdcd_defs.vh"
module lcdcd_top (
  // Clock, synchronous reset and clock enable.
  input wire clk,
  input wire reset,
  input wire clk_en,
  // Reset pin, active low, asynchronous to clk.
  input wire hw_reset_n,
  // Host byte port.
  input wire host_valid,
  output wire host_ready,
  input wire reg_select,
  input wire read_not_write,
  input wire [7:0] host_data,
  input wire serial_sel,
  // Read answer.
  output reg rd_valid_q,
  output reg [7:0] rd_data_q,
  // Display control settings.
  output reg display_on_q,
  output reg inverse_flag_q,
  output reg all_pixels_flag_q,
  output reg seg_reverse_q,
  output reg com_reverse_q,
  output reg power_save_q,
  output reg [5:0] start_line_q,
  // Power circuit settings.
  output reg bias_sel_q,
  output reg [1:0] booster_level_q,
  output reg booster_en_q,
  output reg regulator_en_q,
  output reg follower_en_q,
  output reg [2:0] reg_ratio_q,
  output reg [5:0] volume_level_q,
  // Address counters and modes.
  output reg [3:0] page_q,
  output reg [7:0] column_q,
  output reg rmw_q,
  output reg static_ind_on_q,
  output reg [1:0] static_indicator_reg_q,
  output reg test_mode_q,
  output reg serial_clear_q,
  // Status.
  output reg busy_q,
  output reg reset_active_q
);
  reg hwr_s1_q;
  reg hwr_s2_q;
  reg [7:0] rst_cnt_q;
  reg [1:0] pend_q;
  reg [7:0] rmw_col_q;
  reg [7:0] mem [0:`LCDCD_MEM_WORDS-1];
  wire [31:0] rst_cyc_w;
  wire f_valid;
  wire [9:0] f_data;
  wire f_rs;
  wire f_rd;
  wire [7:0] d;
  wire hw_low;
  wire counting;
  wire is_status;
  wire take;
  wire cmd_wr;
  wire dat_wr;
  wire dat_rd;
  wire page_ok;
  wire [10:0] idx;
  wire [7:0] mem_rd;
  wire sw_rst;
  wire do_common;
  wire col_step;

  // Word index of a page and column in the flat memory.
  function [10:0] mem_index;
    input [3:0] pg;
    input [7:0] col;
    reg [10:0] prod;
    begin
      prod = {7'h00, pg} * 11'h084;
      mem_index = prod + {3'h0, col};
    end
  endfunction

  // Opcode match on the fixed bits selected by a mask.
  function op_is;
    input [7:0] val;
    input [7:0] mask;
    input [7:0] op;
    begin
      op_is = ((val & mask) == op);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host FIFO. Its ready goes back to the host so a busy decoder stalls it.
  lcdcd_fifo #(
    .W(`LCDCD_FIFO_W),
    .D(`LCDCD_FIFO_D),
    .AW(`LCDCD_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_valid(host_valid),
    .in_ready_q(host_ready),
    .in_data({reg_select, read_not_write, host_data}),
    .out_valid(f_valid),
    .out_ready(take),
    .out_data(f_data)
  );

  assign rst_cyc_w = `LCDCD_RST_CYC;
  assign f_rs = f_data[9];
  assign f_rd = f_data[8];
  assign d = f_data[7:0];
  assign hw_low = ~hwr_s2_q;
  assign counting = (rst_cnt_q != 8'h00);
  assign is_status = ~f_rs & f_rd;
  // Bytes drain while the pin is low so they are rejected, not queued;
  // during the timed procedure only status reads pass.
  assign take = clk_en & f_valid & (hw_low | ~counting | is_status);
  assign cmd_wr = take & ~hw_low & ~f_rs & ~f_rd;
  assign dat_wr = take & ~hw_low & f_rs & ~f_rd;
  // Serial mode has no read path at all.
  assign dat_rd = take & ~hw_low & f_rs & f_rd & ~serial_sel;
  // Columns past the last one would alias into the next page, or run past
  // the end of storage on the icon page, so such accesses are dropped.
  assign page_ok = (page_q < `LCDCD_PAGES) &
                   (column_q <= `LCDCD_LAST_COL);
  assign idx = mem_index(page_q, column_q);
  assign mem_rd = page_ok ? mem[idx] : 8'h00;
  assign sw_rst = cmd_wr & (pend_q == `LCDCD_PEND_NONE) &
                  (d == `LCDCD_OP_SRST);
  assign do_common = hw_low | sw_rst;
  // Reads in RMW mode leave the column alone.
  assign col_step = dat_wr | (dat_rd & ~rmw_q);

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser for the reset pin.
  always @(posedge clk) begin
    if (reset) begin
      hwr_s1_q <= 1'b0;
      hwr_s2_q <= 1'b0;
    end else if (clk_en) begin
      hwr_s1_q <= hw_reset_n;
      hwr_s2_q <= hwr_s1_q;
    end
  end

  // Display memory; the icon page keeps only bit 0.
  always @(posedge clk) begin
    if (clk_en & dat_wr & page_ok) begin
      if (page_q == `LCDCD_ICON_PAGE) begin
        mem[idx] <= {7'h00, d[0]};
      end else begin
        mem[idx] <= d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset procedure timer, busy and reset status.
  always @(posedge clk) begin
    if (reset) begin
      rst_cnt_q <= rst_cyc_w[7:0];
      busy_q <= 1'b1;
      reset_active_q <= 1'b1;
    end else if (clk_en) begin
      if (do_common) begin
        rst_cnt_q <= rst_cyc_w[7:0];
      end else if (counting) begin
        rst_cnt_q <= rst_cnt_q - 8'h01;
      end
      busy_q <= do_common | (rst_cnt_q > 8'h01);
      reset_active_q <= do_common | (rst_cnt_q > 8'h01);
    end
  end

  // Read answers: status and display data, one-cycle valid pulse.
  always @(posedge clk) begin
    if (reset) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else if (clk_en) begin
      rd_valid_q <= 1'b0;
      if (take & is_status & ~serial_sel) begin
        rd_valid_q <= 1'b1;
        // Direction and display bits use the inverted status sense.
        rd_data_q <= {busy_q, ~seg_reverse_q, ~display_on_q,
                      reset_active_q, 4'h0};
      end else if (dat_rd) begin
        rd_valid_q <= 1'b1;
        rd_data_q <= mem_rd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decoder. Shared reset defaults come last so they override any
  // decode in the same cycle; a plain reset acts as the pin does.
  always @(posedge clk) begin
    if (reset | (clk_en & hw_low)) begin
      display_on_q <= 1'b0;
      inverse_flag_q <= 1'b0;
      all_pixels_flag_q <= 1'b0;
      seg_reverse_q <= 1'b0;
      serial_clear_q <= 1'b1;
      bias_sel_q <= 1'b0;
      booster_level_q <= 2'h0;
      power_save_q <= 1'b0;
      booster_en_q <= 1'b0;
      regulator_en_q <= 1'b0;
      follower_en_q <= 1'b0;
    end else if (clk_en) begin
      serial_clear_q <= 1'b0;
      // Power save is the pair display off plus all pixels on.
      power_save_q <= ~display_on_q & all_pixels_flag_q;
      if (cmd_wr) begin
        if (pend_q == `LCDCD_PEND_VOL) begin
          volume_level_q <= d[5:0];
        end else if (pend_q == `LCDCD_PEND_BOOST) begin
          booster_level_q <= d[1:0];
        end else if (op_is(d, `LCDCD_M7, `LCDCD_OP_DISP)) begin
          display_on_q <= d[0];
        end else if (op_is(d, `LCDCD_M6, `LCDCD_OP_LINE)) begin
          start_line_q <= d[5:0];
        end else if (op_is(d, `LCDCD_M4, `LCDCD_OP_PAGE)) begin
          page_q <= d[3:0];
        end else if (op_is(d, `LCDCD_M4, `LCDCD_OP_COLH)) begin
          column_q <= {d[3:0], column_q[3:0]};
        end else if (op_is(d, `LCDCD_M4, `LCDCD_OP_COLL)) begin
          column_q <= {column_q[7:4], d[3:0]};
        end else if (op_is(d, `LCDCD_M7, `LCDCD_OP_SDIR)) begin
          seg_reverse_q <= d[0];
        end else if (op_is(d, `LCDCD_M7, `LCDCD_OP_INVERSE)) begin
          inverse_flag_q <= d[0];
        end else if (op_is(d, `LCDCD_M7, `LCDCD_OP_ALLP)) begin
          all_pixels_flag_q <= d[0];
        end else if (op_is(d, `LCDCD_M7, `LCDCD_OP_BIAS)) begin
          bias_sel_q <= d[0];
        end else if (op_is(d, `LCDCD_M4, `LCDCD_OP_CDIR)) begin
          com_reverse_q <= d[3];
        end else if (d == `LCDCD_OP_RMW) begin
          if (~rmw_q) begin
            rmw_col_q <= column_q;
          end
          rmw_q <= 1'b1;
        end else if (d == `LCDCD_OP_END) begin
          if (rmw_q) begin
            column_q <= rmw_col_q;
          end
          rmw_q <= 1'b0;
        end else if (op_is(d, `LCDCD_M3, `LCDCD_OP_PWR)) begin
          booster_en_q <= d[2];
          regulator_en_q <= d[1];
          follower_en_q <= d[0];
        end else if (op_is(d, `LCDCD_M3, `LCDCD_OP_RATIO)) begin
          reg_ratio_q <= d[2:0];
        end else if (d == `LCDCD_OP_VOL) begin
          pend_q <= `LCDCD_PEND_VOL;
        end else if (d == `LCDCD_OP_BOOST) begin
          pend_q <= `LCDCD_PEND_BOOST;
        end else if (op_is(d, `LCDCD_M4, `LCDCD_OP_TEST)) begin
          // Reserved codes only raise a flag; no behaviour hangs on it,
          // so a stray code cannot upset the settings.
          test_mode_q <= 1'b1;
        end
        // The NOP byte and unknown codes fall through unchanged.
        if (pend_q != `LCDCD_PEND_NONE) begin
          pend_q <= `LCDCD_PEND_NONE;
        end
      end else if (col_step) begin
        if (column_q < `LCDCD_LAST_COL) begin
          column_q <= column_q + 8'h01;
        end
      end
    end
    // Defaults shared by both reset kinds.
    if (reset | (clk_en & do_common)) begin
      rmw_q <= 1'b0;
      rmw_col_q <= 8'h00;
      static_ind_on_q <= 1'b0;
      static_indicator_reg_q <= 2'h0;
      start_line_q <= 6'h00;
      column_q <= 8'h00;
      page_q <= 4'h0;
      com_reverse_q <= 1'b0;
      reg_ratio_q <= `LCDCD_RST_RATIO;
      volume_level_q <= `LCDCD_RST_VOLUME;
      test_mode_q <= 1'b0;
      pend_q <= `LCDCD_PEND_NONE;
    end
  end
endmodule
`default_nettype wire

// >>> test/lcdcd_asserts.sv
// Concurrent checks on the ports of the LCD command decoder.
`timescale 1ns/1ns
`default_nettype none
module lcdcd_asserts (
  // Clock and reset.
  input wire clk,
  input wire reset,
  // Host side.
  input wire hw_reset_n,
  input wire host_valid,
  input wire host_ready,
  input wire reg_select,
  input wire read_not_write,
  input wire serial_sel,
  // Observed outputs.
  input wire rd_valid_q,
  input wire display_on_q,
  input wire all_pixels_flag_q,
  input wire power_save_q,
  input wire [7:0] column_q,
  input wire rmw_q,
  input wire serial_clear_q,
  input wire busy_q,
  input wire reset_active_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Status and reset procedure.
  a_rst_busy: assert property (reset_active_q |-> busy_q)
    else $error("reset in progress without busy");
  a_busy_ends: assert property (
    busy_q && hw_reset_n |-> ##[0:40] !busy_q)
    else $error("busy outlasts the reset procedure");
  a_pin_reset: assert property (
    !hw_reset_n [*4] |=> reset_active_q && !display_on_q && serial_clear_q)
    else $error("low reset pin did not apply defaults");
  a_reset_start: assert property (
    $fell(reset) |-> busy_q && reset_active_q && column_q == 8'h00)
    else $error("wrong state on reset release");

  ////////////////////////////////////////////////////////////////////////////
  // Reads, power save and column stepping.
  a_status_answer: assert property (
    host_valid && host_ready && !reg_select && read_not_write && !serial_sel
    |-> ##[2:80] rd_valid_q)
    else $error("status read went unanswered");
  a_serial_quiet: assert property (serial_sel [*4] |=> !rd_valid_q)
    else $error("read answered in serial mode");
  // A hardware reset leaves power save at once, whatever the flags were.
  a_save_mode: assert property (
    power_save_q == ($past(!display_on_q && all_pixels_flag_q) &&
      !serial_clear_q))
    else $error("power save does not follow display off and all on");
  a_col_no_wrap: assert property (
    $past(column_q) == 8'h83 && !$past(rmw_q)
    |-> column_q != 8'h00 || reset_active_q)
    else $error("column wrapped past the last column");
endmodule
bind lcdcd_top lcdcd_asserts lcdcd_asserts_i (.clk, .reset, .hw_reset_n,
  .host_valid, .host_ready, .reg_select, .read_not_write, .serial_sel,
  .rd_valid_q, .display_on_q, .all_pixels_flag_q, .power_save_q, .column_q,
  .rmw_q, .serial_clear_q, .busy_q, .reset_active_q);
`default_nettype wire

// >>> test/lcdcd_host_model.sv
// Behavioural host processor that offers bytes to the decoder.
`timescale 1ns/1ns
`default_nettype none
module lcdcd_host_model (
  // Clock and flow control.
  input wire logic clk,
  input wire logic host_ready,
  // Byte offered to the decoder.
  output logic host_valid,
  output logic reg_select,
  output logic read_not_write,
  output logic [7:0] host_data
);
  // Idle bus at time zero.
  initial begin
    host_valid = 1'b0;
    reg_select = 1'b0;
    read_not_write = 1'b0;
    host_data = 8'h00;
  end

  // Offer one byte and hold it until an edge sees ready; the bench never
  // offers reserved factory codes, only the booster prefix.
  task automatic put(input logic rs, input logic rw, input logic [7:0] d);
    host_valid <= 1'b1;
    reg_select <= rs;
    read_not_write <= rw;
    host_data <= d;
    @(posedge clk);
    while (host_ready !== 1'b1) @(posedge clk);
  endtask

  // Release the bus; stale data is inverted so it cannot pass for valid.
  task automatic idle;
    host_valid <= 1'b0;
    host_data <= ~host_data;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> test/tb_lcdcd_top.sv
// Self-checking bench for the LCD command decoder.
`timescale 1ns/1ns
`default_nettype none
module tb_lcdcd_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hw_reset_n = 1'b1;
  logic serial_sel = 1'b0;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  wire host_valid, host_ready, reg_select, read_not_write, rd_valid_q;
  wire display_on_q, inverse_flag_q, all_pixels_flag_q, seg_reverse_q;
  wire com_reverse_q, power_save_q, bias_sel_q, booster_en_q, rmw_q;
  wire regulator_en_q, follower_en_q, static_ind_on_q, test_mode_q;
  wire serial_clear_q, busy_q, reset_active_q;
  wire [7:0] host_data, rd_data_q, column_q;
  wire [5:0] start_line_q, volume_level_q;
  wire [1:0] booster_level_q, static_indicator_reg_q;
  wire [2:0] reg_ratio_q;
  wire [3:0] page_q;
  // All settings but page, column and power save in one word so one compare covers them.
  wire [30:0] cfg = {display_on_q, inverse_flag_q, all_pixels_flag_q,
    seg_reverse_q, com_reverse_q, bias_sel_q, booster_en_q, regulator_en_q,
    follower_en_q, booster_level_q, reg_ratio_q, volume_level_q,
    start_line_q, rmw_q, test_mode_q, static_ind_on_q, static_indicator_reg_q};
  logic [7:0] setup [14] = '{8'hAF, 8'hA7, 8'hA5, 8'hA1, 8'hCD, 8'hA3,
    8'h2F, 8'hF8, 8'h03, 8'h25, 8'hE3, 8'h81, 8'h15, 8'h7F};

  lcdcd_top lcdcd_top_i (.clk, .reset, .clk_en(1'b1), .hw_reset_n,
    .host_valid, .host_ready, .reg_select, .read_not_write, .host_data,
    .serial_sel, .rd_valid_q, .rd_data_q, .display_on_q, .inverse_flag_q,
    .all_pixels_flag_q, .seg_reverse_q, .com_reverse_q, .power_save_q,
    .start_line_q, .bias_sel_q, .booster_level_q, .booster_en_q,
    .regulator_en_q, .follower_en_q, .reg_ratio_q, .volume_level_q, .page_q,
    .column_q, .rmw_q, .static_ind_on_q, .static_indicator_reg_q,
    .test_mode_q, .serial_clear_q, .busy_q, .reset_active_q);
  lcdcd_host_model host_i (.clk, .host_ready, .host_valid, .reg_select,
    .read_not_write, .host_data);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling that cuts a hang short.
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test;
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [30:0] got, input logic [30:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Host access helpers.
  task automatic cmd(input logic [7:0] d);
    host_i.put(1'b0, 1'b0, d);
  endtask

  task automatic setcol(input logic [7:0] c);
    cmd({4'h1, c[7:4]});
    cmd({4'h0, c[3:0]});
  endtask

  // Drain the queue and wait out any reset procedure.
  task automatic quiet;
    int n;
    host_i.idle;
    repeat (12) @(posedge clk);
    for (n = 0; n < 80 && busy_q !== 1'b0; n++) @(posedge clk);
    repeat (12) @(posedge clk);
  endtask

  // Read and compare the answer, or its absence when v is low.
  task automatic rd(input logic rs, input logic v, input logic [7:0] exp);
    int n;
    host_i.put(rs, 1'b1, 8'h00);
    host_i.idle;
    for (n = 0; n < 60 && rd_valid_q !== 1'b1; n++) @(posedge clk);
    check({rd_valid_q, rd_data_q}, {v, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    quiet;
    check(cfg, {9'h000, 2'h0, 3'h4, 6'h20, 6'h00, 5'h00});
    rd(1'b0, 1'b1, 8'h60);
    foreach (setup[i]) cmd(setup[i]);
    quiet;
    check(cfg[30:22], 9'h1FF);
    check(cfg[21:17], {2'h3, 3'h5});
    check(cfg[16:0], {6'h15, 6'h3F, 5'h00});
    rd(1'b0, 1'b1, 8'h00);
    cmd(8'hAE);
    quiet;
    check(power_save_q, 1'b1);
    cmd(8'hE2);
    rd(1'b0, 1'b1, 8'hB0);
    quiet;
    check(cfg, {9'h0EF, 2'h3, 3'h4, 6'h20, 6'h00, 5'h00});
    cmd(8'hB3);
    setcol(8'h82);
    host_i.put(1'b1, 1'b0, 8'hAA);
    host_i.put(1'b1, 1'b0, 8'hBB);
    host_i.put(1'b1, 1'b0, 8'hCC);
    quiet;
    check({page_q, column_q}, 12'h383);
    setcol(8'h82);
    rd(1'b1, 1'b1, 8'hAA);
    rd(1'b1, 1'b1, 8'hCC);
    setcol(8'h82);
    cmd(8'hE0);
    rd(1'b1, 1'b1, 8'hAA);
    check(column_q, 8'h82);
    host_i.put(1'b1, 1'b0, 8'h11);
    cmd(8'hEE);
    quiet;
    check(column_q, 8'h82);
    rd(1'b1, 1'b1, 8'h11);
    cmd(8'hB8);
    setcol(8'h00);
    host_i.put(1'b1, 1'b0, 8'hFF);
    setcol(8'h00);
    rd(1'b1, 1'b1, 8'h01);
    serial_sel <= 1'b1;
    rd(1'b1, 1'b0, 8'h01);
    check(column_q, 8'h01);
    serial_sel <= 1'b0;
    hw_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    cmd(8'hAF);
    rd(1'b0, 1'b1, 8'hF0);
    check({display_on_q, serial_clear_q}, 2'b01);
    hw_reset_n <= 1'b1;
    quiet;
    check(cfg, {9'h000, 2'h0, 3'h4, 6'h20, 6'h00, 5'h00});
    check({page_q, column_q}, 12'h000);
    finish_test;
  end
endmodule
`default_nettype wire
